/* File: include/usb_ep_pkg.sv */
// Package for the endpoint control block: register offsets, field positions,
// reset values, endpoint kind encodings and the packed carriers.
// Assumes a single 125 MHz clock domain and a word-indexed register port.
package usb_ep_pkg;

    // Register index map: index 0 of each group is endpoint 0.
    localparam logic [7:0] CSR_BASE     = 8'h00;
    localparam logic [7:0] FIFO_BASE    = 8'h10;
    localparam logic [7:0] XCVR_OFFSET  = 8'h20;
    localparam logic [7:0] EPRST_OFFSET = 8'h21;

    // Control and status field positions.
    localparam int BIT_TXDONE    = 0;
    localparam int BIT_BK0       = 1;
    localparam int BIT_SETUP     = 2;
    localparam int BIT_STALLACK  = 3;
    localparam int BIT_PKTRDY    = 4;
    localparam int BIT_FSTALL    = 5;
    localparam int BIT_BK1       = 6;
    localparam int BIT_DIR       = 7;
    localparam int KIND_LSB      = 8;
    localparam int BIT_TOGGLE    = 11;
    localparam int BIT_EPON      = 15;
    localparam int COUNT_LSB     = 16;
    localparam int BIT_PHYOFF    = 8;

    // Reset values.
    localparam logic [2:0] KIND_RESET = 3'h0;
    localparam logic       PHY_OFF_RESET = 1'b0;

    // Endpoint kinds.
    localparam logic [2:0] KIND_CONTROL  = 3'h0;
    localparam logic [2:0] KIND_ISO_OUT  = 3'h1;
    localparam logic [2:0] KIND_ISO_IN   = 3'h5;
    localparam logic [2:0] KIND_BULK_OUT = 3'h2;
    localparam logic [2:0] KIND_BULK_IN  = 3'h6;
    localparam logic [2:0] KIND_INTR_OUT = 3'h3;
    localparam logic [2:0] KIND_INTR_IN  = 3'h7;

    // Serial engine events, one endpoint per event.
    typedef struct packed {
        logic       rx_done;     // OUT data packet accepted
        logic       rx_setup;    // SETUP packet accepted
        logic       rx_crc_err;  // Isochronous packet with CRC error
        logic       rx_toggle;   // PID toggle of accepted OUT packet
        logic       in_acked;    // Host acknowledged IN payload
        logic       stall_acked; // STALL handshake sent and ended
        logic [2:0] ep;
    } link_event_s;

    // Byte stream between serial engine and endpoint FIFO.
    typedef struct packed {
        logic       valid;
        logic [2:0] ep;
        logic [7:0] data;
    } link_byte_s;

endpackage

/* File: rtl/usb_ep_ctrl.sv */
// Endpoint control and status logic of a full-speed USB device port.
// Assumes the serial engine runs in the i_clk domain and reports events
// as one-cycle pulses; firmware uses the plain strobe register port.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - Host-acked STALL sets stall flag; interrupt stays high while set.
// - Writing zero clears stall or iso-error flag; writing one does nothing.
// - On isochronous endpoints same bit reports CRC error and raises interrupt.
// - Packet-ready blocks FIFO writes; host ack clears it and sets complete.
// - Writing one to force-stall makes endpoint answer STALL; zero ignored.
// - Forced stall means request failed or endpoint halted, by kind.
// - Ping-pong endpoint stores packet in bank one, sets flag, interrupts.
// - Direction bit zero allows OUT, one enables IN in control data stage.
// - Three-bit kind encodes control, iso, bulk and interrupt, OUT and IN.
// - Read-only toggle bit reads zero for DATA0, one for DATA1.
// - Enable bit writes enable or disable endpoint; reads return state.
// - Eleven-bit read-only count shows received bytes available in FIFO.
// - Byte FIFO port pushes on each write and pops on each read.
// - Transceiver-disable bit powers down the PHY; clearing re-enables it.
// - While setup flag is set, further OUT transactions are refused.
// - Transmit-complete keeps interrupt while set; zero clears, one ignored.
// - Endpoint reset zeroes pointers, count and toggle; flags kept.
module usb_ep_ctrl #(
    parameter int NUM_EP    = 8,
    parameter int PP_EP_MAP = 8'h06,
    parameter int FIFO_AW   = 6
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic [7:0]                i_addr,
    input  wire logic [31:0]               i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [31:0]               o_rdata,
    input  wire usb_ep_pkg::link_event_s   i_evt,
    input  wire usb_ep_pkg::link_byte_s    i_rx_byte,
    input  wire logic                      i_tx_pop,
    input  wire logic [2:0]                i_tx_ep,
    output logic      [7:0]                o_tx_data,
    output logic      [NUM_EP-1:0]         o_ep_irq,
    output logic      [NUM_EP-1:0]         o_ep_stall,
    output logic      [NUM_EP-1:0]         o_out_accept,
    output logic      [NUM_EP-1:0]         o_in_ready,
    output logic      [NUM_EP-1:0]         o_in_dir,
    output logic      [NUM_EP-1:0]         o_tx_toggle,
    output logic                           o_phy_power_down
);

    localparam int DEPTH = 1 << FIFO_AW;

    // Per-endpoint state, then the shared PHY, read data and transmit data registers.
    logic [NUM_EP-1:0] in_transfer_complete_ff;
    logic [NUM_EP-1:0] rx_bank_zero_full_ff;
    logic [NUM_EP-1:0] rx_bank_one_full_ff;
    logic [NUM_EP-1:0] setup_received_flag_ff;
    logic [NUM_EP-1:0] stall_acked_flag_ff;
    logic [NUM_EP-1:0] in_packet_ready_ff;
    logic [NUM_EP-1:0] force_stall_cmd_ff;
    logic [NUM_EP-1:0] dir_ff;
    logic [NUM_EP-1:0] packet_toggle_state_ff;
    logic [NUM_EP-1:0] endpoint_on_ff;
    logic [NUM_EP-1:0] endpoint_reset_bits_ff;
    logic [2:0]        endpoint_kind_ff [NUM_EP];
    logic [10:0]       received_byte_count_ff [NUM_EP];
    logic [FIFO_AW-1:0] wptr_ff [NUM_EP];
    logic [FIFO_AW-1:0] rptr_ff [NUM_EP];
    logic [7:0]        mem_ff [NUM_EP][DEPTH];
    logic              phy_power_down_ff;
    logic [31:0]       rdata_ff;
    logic [7:0]        tx_data_ff;

    // True when a register index hits one endpoint of a group.
    function automatic logic ep_hit(input logic [7:0] addr, input logic [7:0] base,
                                    input int ep);
        ep_hit = (addr == base + 8'(ep));
    endfunction

    // Assembles the control and status word of one endpoint.
    function automatic logic [31:0] csr_word(input int ep);
        logic [31:0] w;
        w = 32'h0;
        w[usb_ep_pkg::BIT_TXDONE]   = in_transfer_complete_ff[ep];
        w[usb_ep_pkg::BIT_BK0]      = rx_bank_zero_full_ff[ep];
        w[usb_ep_pkg::BIT_SETUP]    = setup_received_flag_ff[ep];
        w[usb_ep_pkg::BIT_STALLACK] = stall_acked_flag_ff[ep];
        w[usb_ep_pkg::BIT_PKTRDY]   = in_packet_ready_ff[ep];
        w[usb_ep_pkg::BIT_BK1]      = rx_bank_one_full_ff[ep];
        w[usb_ep_pkg::BIT_DIR]      = dir_ff[ep];
        w[usb_ep_pkg::KIND_LSB +: 3] = endpoint_kind_ff[ep];
        w[usb_ep_pkg::BIT_TOGGLE]   = packet_toggle_state_ff[ep];
        w[usb_ep_pkg::BIT_EPON]     = endpoint_on_ff[ep];
        w[usb_ep_pkg::COUNT_LSB +: 11] = received_byte_count_ff[ep];
        csr_word = w;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            logic csr_wr;
            logic fifo_wr;
            logic fifo_rd;
            logic is_iso;
            logic rx_hit;
            logic pop_hit;
            logic evt_hit;
            logic use_bk1;
            assign csr_wr  = i_wr && ep_hit(i_addr, usb_ep_pkg::CSR_BASE, g);
            assign fifo_wr = i_wr && ep_hit(i_addr, usb_ep_pkg::FIFO_BASE, g)
                             && !in_packet_ready_ff[g];
            assign fifo_rd = i_rd && ep_hit(i_addr, usb_ep_pkg::FIFO_BASE, g);
            assign is_iso  = endpoint_kind_ff[g][1:0] == usb_ep_pkg::KIND_ISO_OUT[1:0];
            assign rx_hit  = i_rx_byte.valid && i_rx_byte.ep == 3'(g) && o_out_accept[g];
            assign pop_hit = i_tx_pop && i_tx_ep == 3'(g);
            assign evt_hit = i_evt.ep == 3'(g);
            assign use_bk1 = PP_EP_MAP[g] && rx_bank_zero_full_ff[g];

            // Hardware-set flags win over a same-cycle firmware clear.
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    in_transfer_complete_ff[g] <= 1'b0;
                    rx_bank_zero_full_ff[g]    <= 1'b0;
                    rx_bank_one_full_ff[g]     <= 1'b0;
                    setup_received_flag_ff[g]  <= 1'b0;
                    stall_acked_flag_ff[g]     <= 1'b0;
                    in_packet_ready_ff[g]      <= 1'b0;
                    force_stall_cmd_ff[g]      <= 1'b0;
                end
                else
                begin
                    if (csr_wr && !i_wdata[usb_ep_pkg::BIT_TXDONE])
                        in_transfer_complete_ff[g] <= 1'b0;
                    if (csr_wr && !i_wdata[usb_ep_pkg::BIT_BK0])
                        rx_bank_zero_full_ff[g] <= 1'b0;
                    if (csr_wr && !i_wdata[usb_ep_pkg::BIT_BK1])
                        rx_bank_one_full_ff[g] <= 1'b0;
                    if (csr_wr && !i_wdata[usb_ep_pkg::BIT_SETUP])
                        setup_received_flag_ff[g] <= 1'b0;
                    if (csr_wr && !i_wdata[usb_ep_pkg::BIT_STALLACK])
                        stall_acked_flag_ff[g] <= 1'b0;
                    if (csr_wr && i_wdata[usb_ep_pkg::BIT_PKTRDY])
                        in_packet_ready_ff[g] <= 1'b1;
                    if (csr_wr && i_wdata[usb_ep_pkg::BIT_FSTALL])
                        force_stall_cmd_ff[g] <= 1'b1;
                    if (evt_hit && i_evt.in_acked)
                    begin
                        in_packet_ready_ff[g]      <= 1'b0;
                        in_transfer_complete_ff[g] <= 1'b1;
                    end
                    if (evt_hit && i_evt.stall_acked)
                    begin
                        stall_acked_flag_ff[g] <= 1'b1;
                        force_stall_cmd_ff[g]  <= 1'b0;
                    end
                    if (evt_hit && i_evt.rx_crc_err && is_iso)
                        stall_acked_flag_ff[g] <= 1'b1;
                    if (evt_hit && i_evt.rx_setup)
                        setup_received_flag_ff[g] <= 1'b1;
                    if (evt_hit && i_evt.rx_done)
                    begin
                        if (use_bk1)
                            rx_bank_one_full_ff[g] <= 1'b1;
                        else
                            rx_bank_zero_full_ff[g] <= 1'b1;
                    end
                end
            end

            // Software-owned configuration; reads-only fields take no write.
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    dir_ff[g]              <= 1'b0;
                    endpoint_on_ff[g]      <= 1'b0;
                    endpoint_kind_ff[g]    <= usb_ep_pkg::KIND_RESET;
                end
                else if (csr_wr)
                begin
                    dir_ff[g]           <= i_wdata[usb_ep_pkg::BIT_DIR];
                    endpoint_on_ff[g]   <= i_wdata[usb_ep_pkg::BIT_EPON];
                    endpoint_kind_ff[g] <= i_wdata[usb_ep_pkg::KIND_LSB +: 3];
                end
            end

            // Toggle tracks accepted packets; endpoint reset returns it to DATA0.
            always_ff @(posedge i_clk)
            begin
                if (i_rst || endpoint_reset_bits_ff[g])
                    packet_toggle_state_ff[g] <= 1'b0;
                else if (evt_hit && (i_evt.rx_done || i_evt.rx_setup))
                    packet_toggle_state_ff[g] <= i_evt.rx_toggle;
                else if (evt_hit && i_evt.in_acked)
                    packet_toggle_state_ff[g] <= ~packet_toggle_state_ff[g];
            end

            // Byte FIFO pointers and count. A single shared buffer per endpoint
            // keeps area low; the pointers wrap at the physical depth, the 11-bit count at 2048.
            always_ff @(posedge i_clk)
            begin
                if (i_rst || endpoint_reset_bits_ff[g])
                begin
                    wptr_ff[g] <= '0;
                    rptr_ff[g] <= '0;
                    received_byte_count_ff[g] <= 11'h000;
                end
                else
                begin
                    if (fifo_wr || rx_hit)
                        wptr_ff[g] <= wptr_ff[g] + 1'b1;
                    if (fifo_rd || pop_hit)
                        rptr_ff[g] <= rptr_ff[g] + 1'b1;
                    if (rx_hit && !fifo_rd)
                        received_byte_count_ff[g] <= received_byte_count_ff[g] + 11'h001;
                    else if (fifo_rd && !rx_hit && received_byte_count_ff[g] != 11'h000)
                        received_byte_count_ff[g] <= received_byte_count_ff[g] - 11'h001;
                end
            end

            // Buffer storage, written by firmware or the receive stream.
            always_ff @(posedge i_clk)
            begin
                if (fifo_wr)
                    mem_ff[g][wptr_ff[g]] <= i_wdata[7:0];
                else if (rx_hit)
                    mem_ff[g][wptr_ff[g]] <= i_rx_byte.data;
            end

            // Link-facing qualifiers and interrupt, all registered.
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    o_ep_irq[g]     <= 1'b0;
                    o_ep_stall[g]   <= 1'b0;
                    o_out_accept[g] <= 1'b0;
                    o_in_ready[g]   <= 1'b0;
                    o_in_dir[g]     <= 1'b0;
                    o_tx_toggle[g]  <= 1'b0;
                end
                else
                begin
                    o_ep_irq[g] <= in_transfer_complete_ff[g] | rx_bank_zero_full_ff[g]
                                 | rx_bank_one_full_ff[g] | setup_received_flag_ff[g]
                                 | stall_acked_flag_ff[g];
                    o_ep_stall[g]   <= force_stall_cmd_ff[g] && endpoint_on_ff[g];
                    o_out_accept[g] <= endpoint_on_ff[g] && !setup_received_flag_ff[g]
                                       && !(rx_bank_zero_full_ff[g]
                                            && (!PP_EP_MAP[g] || rx_bank_one_full_ff[g]));
                    o_in_ready[g]   <= endpoint_on_ff[g] && in_packet_ready_ff[g];
                    o_in_dir[g]     <= dir_ff[g];
                    o_tx_toggle[g]  <= packet_toggle_state_ff[g];
                end
            end
        end
    endgenerate

    // Global controls: transceiver power-down and endpoint reset bits.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            phy_power_down_ff      <= usb_ep_pkg::PHY_OFF_RESET;
            endpoint_reset_bits_ff <= '0;
        end
        else
        begin
            if (i_wr && i_addr == usb_ep_pkg::XCVR_OFFSET)
                phy_power_down_ff <= i_wdata[usb_ep_pkg::BIT_PHYOFF];
            if (i_wr && i_addr == usb_ep_pkg::EPRST_OFFSET)
                endpoint_reset_bits_ff <= i_wdata[NUM_EP-1:0];
        end
    end

    // Read data stands the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdata_ff <= 32'h0;
        else
        begin
            rdata_ff <= 32'h0;
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (i_rd && ep_hit(i_addr, usb_ep_pkg::CSR_BASE, e))
                    rdata_ff <= csr_word(e);
                if (i_rd && ep_hit(i_addr, usb_ep_pkg::FIFO_BASE, e))
                    rdata_ff <= {24'h0, mem_ff[e][rptr_ff[e]]};
            end
            if (i_rd && i_addr == usb_ep_pkg::XCVR_OFFSET)
                rdata_ff[usb_ep_pkg::BIT_PHYOFF] <= phy_power_down_ff;
            if (i_rd && i_addr == usb_ep_pkg::EPRST_OFFSET)
                rdata_ff[NUM_EP-1:0] <= endpoint_reset_bits_ff;
        end
    end

    // Byte handed to the serial engine on each pop, one cycle later.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            tx_data_ff <= 8'h00;
        else if (i_tx_pop)
            tx_data_ff <= mem_ff[i_tx_ep][rptr_ff[i_tx_ep]];
    end

    assign o_rdata          = rdata_ff;
    assign o_tx_data        = tx_data_ff;
    assign o_phy_power_down = phy_power_down_ff;

endmodule

/* File: sim/usb_ep_ctrl_properties.sv */
// Concurrent checks on the ports of the endpoint control block.
// Assumes one clock, synchronous active-high reset; bound below.
`timescale 1ns/1ps
module usb_ep_ctrl_properties #(
    parameter int NUM_EP = 8
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic [7:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    input  wire logic [31:0]             o_rdata,
    input  wire usb_ep_pkg::link_event_s i_evt,
    input  wire usb_ep_pkg::link_byte_s  i_rx_byte,
    input  wire logic                    i_tx_pop,
    input  wire logic [2:0]              i_tx_ep,
    input  wire logic [7:0]              o_tx_data,
    input  wire logic [NUM_EP-1:0]       o_ep_irq,
    input  wire logic [NUM_EP-1:0]       o_ep_stall,
    input  wire logic [NUM_EP-1:0]       o_out_accept,
    input  wire logic [NUM_EP-1:0]       o_in_ready,
    input  wire logic [NUM_EP-1:0]       o_in_dir,
    input  wire logic [NUM_EP-1:0]       o_tx_toggle,
    input  wire logic                    o_phy_power_down
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // A link event, then two edges until the outputs show it.
    sequence s_ev2(ev);
        ev ##2 1'b1;
    endsequence
    // A firmware write to a control word with a qualifying bit.
    sequence s_csr_wr(b);
        i_wr && (i_addr < 8'h08) && b;
    endsequence

    a_stall_ack_irq: assert property (s_ev2(i_evt.stall_acked) |-> o_ep_irq[$past(i_evt.ep, 2)] && !o_ep_stall[$past(i_evt.ep, 2)]) else $error("stall ack no irq");
    a_iso_err_irq: assert property (s_ev2(i_evt.rx_crc_err) |-> o_ep_irq[$past(i_evt.ep, 2)]) else $error("iso error no irq");
    a_in_ack_done: assert property (s_ev2(i_evt.in_acked) |-> !o_in_ready[$past(i_evt.ep, 2)] && o_ep_irq[$past(i_evt.ep, 2)]) else $error("in ack not reported");
    a_setup_blocks_out: assert property (s_ev2(i_evt.rx_setup) |-> !o_out_accept[$past(i_evt.ep, 2)] && o_ep_irq[$past(i_evt.ep, 2)]) else $error("setup let out pass");
    a_force_stall_on: assert property (s_csr_wr(i_wdata[5] && i_wdata[15]) |-> ##2 o_ep_stall[$past(i_addr[2:0], 2)]) else $error("forced stall missing");
    a_ep_off_quiet: assert property (s_csr_wr(!i_wdata[15]) |-> ##2 !(o_out_accept[$past(i_addr[2:0], 2)] || o_in_ready[$past(i_addr[2:0], 2)])) else $error("disabled endpoint active");
    a_dir_follows: assert property (s_csr_wr(1'b1) |-> ##2 o_in_dir[$past(i_addr[2:0], 2)] == $past(i_wdata[7], 2)) else $error("dir bit not applied");
    a_phy_follows: assert property (i_wr && i_addr == usb_ep_pkg::XCVR_OFFSET |-> ##2 o_phy_power_down == $past(i_wdata[8], 2)) else $error("phy bit not applied");
    a_toggle_reset: assert property (i_wr && i_addr == usb_ep_pkg::EPRST_OFFSET |-> ##3 (o_tx_toggle & $past(i_wdata[NUM_EP-1:0], 3)) == '0) else $error("toggle not reset");
endmodule

bind usb_ep_ctrl usb_ep_ctrl_properties #(.NUM_EP(NUM_EP)) u_usb_ep_ctrl_properties (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(i_evt), .i_rx_byte(i_rx_byte),
    .i_tx_pop(i_tx_pop), .i_tx_ep(i_tx_ep), .o_tx_data(o_tx_data), .o_ep_irq(o_ep_irq),
    .o_ep_stall(o_ep_stall), .o_out_accept(o_out_accept), .o_in_ready(o_in_ready),
    .o_in_dir(o_in_dir), .o_tx_toggle(o_tx_toggle), .o_phy_power_down(o_phy_power_down));

/* File: sim/usb_ep_ctrl_tb_top.sv */
// Self-checking bench for the endpoint control block.
// Assumes the host model on the link side and the default design parameters.
`timescale 1ns/1ps
module usb_ep_ctrl_tb_top;
    logic                    i_clk, i_rst, i_wr, i_rd, pop, tg, phy;
    logic [7:0]              i_addr, txd, b, irq, stl, acc, dir, rdy, tgl;
    logic [31:0]             i_wdata, o_rdata, d;
    logic [2:0]              pep, ek;
    logic [47:0]             ov;
    usb_ep_pkg::link_event_s evt;
    usb_ep_pkg::link_byte_s  rxb;
    logic [7:0]              q[$];
    logic [2:0]              kinds[7] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int                      fail_count = 0;
    int                      tests_run = 0;
    int                      n;

    assign ov = {7'h0, phy, rdy, dir, acc, stl, irq};
    usb_ep_ctrl u_usb_ep_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(evt),
        .i_rx_byte(rxb), .i_tx_pop(pop), .i_tx_ep(pep), .o_tx_data(txd), .o_ep_irq(irq),
        .o_ep_stall(stl), .o_out_accept(acc), .o_in_ready(rdy), .o_in_dir(dir),
        .o_tx_toggle(tgl), .o_phy_power_down(phy));
    usb_host_model u_usb_host_model (.i_clk(i_clk), .i_tx_data(txd), .o_evt(evt),
        .o_rx_byte(rxb), .o_tx_pop(pop), .o_tx_ep(pep));

    // Free-running 125 MHz clock.
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Enabled control word of the given kind.
    function automatic logic [31:0] csrv(input logic [2:0] k);
        return 32'h0000_8000 | {21'h0, k, 8'h00};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // Read data stand one cycle only, so they are taken mid-cycle.
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(o_rdata & m, e);
        @(posedge i_clk);
    endtask
    // Output bits: irq 0-7, stall 8-15, accept 16-23, dir 24-31, ready 32-39, phy 40.
    task automatic ochk(input int i, input logic e);
        @(negedge i_clk);
        chk(32'(ov[i]), 32'(e));
        @(posedge i_clk);
    endtask
    task automatic rx_pkt(input logic [2:0] ep, input int cnt, input logic [5:0] k);
        for (int i = 0; i < cnt; i++)
        begin
            b = 8'($urandom);
            q.push_back(b);
            u_usb_host_model.put(ep, b);
        end
        u_usb_host_model.evt(k, ep);
    endtask
    task automatic drain(input logic [2:0] ep);
        while (q.size() > 0)
            rchk(usb_ep_pkg::FIFO_BASE + 8'(ep), 32'hFF, 32'(q.pop_front()));
    endtask
    // One IN payload, a refused extra byte, then the host's ack.
    task automatic in_round(input int cnt);
        rchk(8'h03, 32'h10, 32'h0);
        for (int i = 0; i < cnt; i++)
        begin
            q.push_back(8'($urandom));
            wr(usb_ep_pkg::FIFO_BASE + 8'h03, 32'(q[i]));
        end
        wr(8'h03, csrv(usb_ep_pkg::KIND_BULK_IN) | 32'h10);
        wr(usb_ep_pkg::FIFO_BASE + 8'h03, 32'h5A);
        ochk(35, 1'b1);
        rchk(8'h03, 32'h10, 32'h10);
        while (q.size() > 0)
        begin
            u_usb_host_model.pop(3'h3, b);
            chk(32'(b), 32'(q.pop_front()));
        end
        u_usb_host_model.evt(6'h02, 3'h3);
        tg = ~tg;
        rchk(8'h03, 32'h0811, {20'h0, tg, 11'h1});
        wr(8'h03, csrv(usb_ep_pkg::KIND_BULK_IN));
        ochk(3, 1'b0);
    endtask
    // Hang guard, far above the sequence length.
    initial
    begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial
    begin
        {i_rst, i_addr, i_wdata, i_wr, i_rd, tg} = {1'b1, 43'h0};
        void'($urandom(1));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int e = 0; e < 8; e++)
            rchk(8'(e), 32'hFFFF_FFFF, 32'h0);
        rchk(usb_ep_pkg::XCVR_OFFSET, 32'hFFFF_FFFF, 32'h0);
        rchk(8'h30, 32'hFFFF_FFFF, 32'h0);
        // Every kind; random direction must stick, random toggle and count bits must not.
        for (int k = 0; k < 7; k++)
        begin
            d = $urandom & 32'h07FF_0880;
            wr(8'h01, csrv(kinds[k]) | d);
            rchk(8'h01, 32'h07FF_8F80, csrv(kinds[k]) | (d & 32'h80));
        end
        wr(8'h01, 32'h0);
        rchk(8'h01, 32'h8000, 32'h0);
        // Forced stall on a control and an interrupt endpoint.
        for (int e = 0; e < 2; e++)
        begin
            ek = (e == 0) ? usb_ep_pkg::KIND_CONTROL : usb_ep_pkg::KIND_INTR_IN;
            wr(8'(e), csrv(ek) | 32'h20);
            ochk(8 + e, 1'b1);
            rchk(8'(e), 32'h28, 32'h0);
            u_usb_host_model.evt(6'h01, 3'(e));
            rchk(8'(e), 32'h28, 32'h08);
            wr(8'(e), csrv(ek) | 32'h08);
            rchk(8'(e), 32'h08, 32'h08);
            wr(8'(e), csrv(ek));
            ochk(e, 1'b0);
        end
        wr(8'h04, csrv(usb_ep_pkg::KIND_ISO_OUT));
        u_usb_host_model.evt(6'h08, 3'h4);
        rchk(8'h04, 32'h08, 32'h08);
        wr(8'h04, csrv(usb_ep_pkg::KIND_ISO_OUT));
        rchk(8'h04, 32'h08, 32'h0);
        // Setup blocks OUT data until firmware sets direction and clears it.
        rx_pkt(3'h0, 8, 6'h10);
        rchk(8'h00, 32'h07FF_0004, 32'h0008_0004);
        ochk(16, 1'b0);
        drain(3'h0);
        u_usb_host_model.put(3'h0, 8'h3C);
        wr(8'h00, csrv(usb_ep_pkg::KIND_CONTROL) | 32'h80);
        ochk(16, 1'b1);
        ochk(24, 1'b1);
        rchk(8'h00, 32'h07FF_0004, 32'h0);
        // Ping-pong: second packet lands in bank one.
        wr(8'h02, csrv(usb_ep_pkg::KIND_BULK_OUT));
        n = 1 + $urandom % 16;
        rx_pkt(3'h2, n, 6'h20);
        rchk(8'h02, 32'h07FF_0042, (32'(n) << 16) | 32'h02);
        rx_pkt(3'h2, 1 + $urandom % 16, 6'h20);
        rchk(8'h02, 32'h42, 32'h42);
        drain(3'h2);
        wr(8'h02, csrv(usb_ep_pkg::KIND_BULK_OUT));
        ochk(2, 1'b0);
        rx_pkt(3'h2, 5, 6'h24);
        q.delete();
        wr(usb_ep_pkg::EPRST_OFFSET, 32'h0C);
        rchk(8'h02, 32'h07FF_0802, 32'h02);
        wr(usb_ep_pkg::EPRST_OFFSET, 32'h0);
        wr(8'h03, csrv(usb_ep_pkg::KIND_BULK_IN));
        in_round(1 + $urandom % 16);
        in_round(1);
        wr(usb_ep_pkg::XCVR_OFFSET, 32'h100);
        ochk(40, 1'b1);
        rchk(usb_ep_pkg::XCVR_OFFSET, 32'h100, 32'h100);
        wr(usb_ep_pkg::XCVR_OFFSET, 32'h0);
        ochk(40, 1'b0);
        // Mid-run reset returns the control word to zero.
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rchk(8'h03, 32'hFFFF_FFFF, 32'h0);
        finish_test();
    end
endmodule

/* File: sim/usb_host_model.sv */
// Host and serial engine model: link events, received bytes, transmit pops.
// Assumes its tasks are entered at a rising clock edge.
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic                i_clk,
    input  wire logic [7:0]          i_tx_data,
    output usb_ep_pkg::link_event_s  o_evt,
    output usb_ep_pkg::link_byte_s   o_rx_byte,
    output logic                     o_tx_pop,
    output logic [2:0]               o_tx_ep
);
    // Idle link at time zero.
    initial
    begin
        o_evt = '0;
        o_rx_byte = '0;
        o_tx_pop = 1'b0;
        o_tx_ep = 3'h0;
    end
    // One-cycle event; k holds done, setup, crc, toggle, ack and stall in that order.
    task automatic evt(input logic [5:0] k, input logic [2:0] ep);
        o_evt <= {k, ep};
        @(posedge i_clk);
        o_evt <= '0;
        @(posedge i_clk);
    endtask
    // The lane shows the inverse after a byte, so stale data never pass.
    task automatic put(input logic [2:0] ep, input logic [7:0] b);
        o_rx_byte <= {1'b1, ep, b};
        @(posedge i_clk);
        o_rx_byte <= {1'b0, ep, ~b};
        @(posedge i_clk);
    endtask
    // Pop one byte, taken mid-cycle where the data are settled.
    task automatic pop(input logic [2:0] ep, output logic [7:0] b);
        o_tx_pop <= 1'b1;
        o_tx_ep <= ep;
        @(posedge i_clk);
        o_tx_pop <= 1'b0;
        @(negedge i_clk);
        b = i_tx_data;
        @(posedge i_clk);
    endtask
endmodule
